// >>> inc/flash_status_defines.svh
// Purpose: constants for the flash status poller
// Assumes: 100 MHz core clock, 32-bit classic Wishbone slave
// Notes: offsets are byte addresses, one aligned word each
`ifndef FLASH_STATUS_DEFINES_SVH
`define FLASH_STATUS_DEFINES_SVH

`define FS_ADDR_W 23
`define FS_DATA_W 16

`define FS_REG_CTRL 8'h00
`define FS_REG_ADDR 8'h04
`define FS_REG_WDATA 8'h08
`define FS_REG_STATUS 8'h0c
`define FS_REG_RDATA 8'h10

`define FS_CTRL_POLL 0
`define FS_CTRL_WRITE 1
`define FS_CTRL_READ 2
`define FS_CTRL_ABORT 3

`define FS_ST_BUSY 0
`define FS_ST_DONE 1
`define FS_ST_FAIL 2
`define FS_ST_RBPIN 3
`define FS_ST_ETIMER 4
`define FS_ST_TIMEOUT 5
`define FS_ST_TOGGLE2 6
`define FS_ST_DPOLL 7

`define FS_DQ_POLL 7
`define FS_DQ_TOGGLE1 6
`define FS_DQ_TIMEOUT 5
`define FS_DQ_ETIMER 3
`define FS_DQ_TOGGLE2 2

`define FS_RESET_CMD 16'h00f0
`define FS_RST_ADDR 23'h000000
`define FS_REG_RST 32'h00000000

`define FS_CLK_NS 10
`define FS_RD_NS 70
`define FS_WR_NS 35
`define FS_REC_NS 20
`define FS_RD_CYC ((`FS_RD_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)
`define FS_WR_CYC ((`FS_WR_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)
`define FS_REC_CYC ((`FS_REC_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)

`endif

// >>> inc/flash_status_pkg.sv
// Purpose: types shared by the flash status poller files
// Assumes: flash_status_defines.svh is on the include path
// Notes: widths come from the defines header
`include "flash_status_defines.svh"

package flash_status_pkg;

  typedef struct packed {
    logic write;
    logic [`FS_ADDR_W-1:0] addr;
    logic [`FS_DATA_W-1:0] wdata;
  } flash_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } flash_strobe_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ACT = 2'b01,
    CYC_REC = 2'b10
  } cyc_state_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD1 = 3'b001,
    ST_RD2 = 3'b010,
    ST_RD3 = 3'b011,
    ST_RST = 3'b100,
    ST_SWRD = 3'b101,
    ST_SWWR = 3'b110
  } poll_state_t;

endpackage

// >>> rtl/flash_cycle.sv
// Purpose: one asynchronous flash read or write cycle on the pins
// Assumes: request held stable while o_done is low after i_go
// Notes: every pin output is a flip-flop
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_defines.svh"

module flash_cycle
  import flash_status_pkg::*;
#(
  parameter int unsigned RD_CYC = `FS_RD_CYC,
  parameter int unsigned WR_CYC = `FS_WR_CYC,
  parameter int unsigned REC_CYC = `FS_REC_CYC
)
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_go,
  input wire flash_req_t i_req,
  output logic o_done,
  output logic [`FS_DATA_W-1:0] o_rdata,
  output var flash_strobe_t o_strobe,
  output logic [`FS_ADDR_W-1:0] o_addr,
  output logic [`FS_DATA_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [`FS_DATA_W-1:0] i_dq_in
);

  cyc_state_t state;
  logic [7:0] cnt;
  logic is_write;

  wire logic start = (state == CYC_IDLE) && i_go;
  wire logic cnt_end = (cnt == 8'h00);
  wire logic [7:0] act_len = i_req.write ? 8'(WR_CYC - 1) : 8'(RD_CYC - 1);

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state <= CYC_IDLE;
      cnt <= 8'h00;
      is_write <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= '0;
      o_strobe <= 3'b111;
      o_addr <= '0;
      o_dq_out <= '0;
      o_dq_oe <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state)
        CYC_IDLE:
        begin
          if (start)
          begin
            state <= CYC_ACT;
            cnt <= act_len;
            is_write <= i_req.write;
            o_addr <= i_req.addr;
            o_dq_out <= i_req.wdata;
            o_dq_oe <= i_req.write;
            o_strobe <= {1'b0, i_req.write, ~i_req.write};
          end
        end
        CYC_ACT:
        begin
          if (cnt_end)
          begin
            // data latches in the flash on the rising strobe edge
            state <= CYC_REC;
            cnt <= 8'(REC_CYC - 1);
            o_strobe <= 3'b111;
            if (!is_write)
              o_rdata <= i_dq_in;
          end
          else
            cnt <= cnt - 8'h01;
        end
        CYC_REC:
        begin
          // bus released before done, so the next cycle starts from idle pins
          o_dq_oe <= 1'b0;
          if (cnt_end)
          begin
            state <= CYC_IDLE;
            o_done <= 1'b1;
          end
          else
            cnt <= cnt - 8'h01;
        end
        default:
          state <= CYC_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/flash_status_poller.sv
// Purpose: host-side status poller and command port for an async flash
// Assumes: classic Wishbone slave, ready/busy pin synchronous to clock
// Notes: software sends command sequences one write at a time
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_defines.svh"

module flash_status_poller
  import flash_status_pkg::*;
#(
  parameter int unsigned RD_CYC = `FS_RD_CYC,
  parameter int unsigned WR_CYC = `FS_WR_CYC,
  parameter int unsigned REC_CYC = `FS_REC_CYC
)
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_flash_ce_n,
  output logic o_flash_oe_n,
  output logic o_flash_we_n,
  output logic [`FS_ADDR_W-1:0] o_flash_addr,
  output logic [`FS_DATA_W-1:0] o_flash_dq_out,
  output logic o_flash_dq_oe,
  input wire logic [`FS_DATA_W-1:0] i_flash_dq_in,
  input wire logic i_ready_busy_n_pin
);

  // ----------------------------------------------------------------
  // byte-lane merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  poll_state_t state;
  logic issued;
  logic [`FS_ADDR_W-1:0] op_addr;
  logic [`FS_DATA_W-1:0] wdata;
  logic [`FS_DATA_W-1:0] rdata;
  logic [`FS_DATA_W-1:0] prev_dq;
  logic done_flag;
  logic fail_flag;
  logic etimer;
  logic timeout_seen;
  logic toggle2;
  logic dpoll;
  logic [1:0] poll_reads;

  flash_strobe_t strobe;
  flash_req_t req;
  logic cyc_done;
  logic [`FS_DATA_W-1:0] cyc_rdata;

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  wire logic bus_req = i_wb_cyc && i_wb_stb;
  wire logic wr_ack = bus_req && i_wb_we && o_wb_ack;
  wire logic hit_ctrl = (i_wb_adr == `FS_REG_CTRL);
  wire logic hit_addr = (i_wb_adr == `FS_REG_ADDR);
  wire logic hit_wdata = (i_wb_adr == `FS_REG_WDATA);
  wire logic hit_status = (i_wb_adr == `FS_REG_STATUS);
  wire logic hit_rdata = (i_wb_adr == `FS_REG_RDATA);
  wire logic ctrl_wr = wr_ack && hit_ctrl && i_wb_sel[0];
  wire logic cmd_poll = ctrl_wr && i_wb_dat[`FS_CTRL_POLL];
  wire logic cmd_write = ctrl_wr && i_wb_dat[`FS_CTRL_WRITE];
  wire logic cmd_read = ctrl_wr && i_wb_dat[`FS_CTRL_READ];
  wire logic cmd_abort = ctrl_wr && i_wb_dat[`FS_CTRL_ABORT];
  wire logic status_clr = wr_ack && hit_status && i_wb_sel[0];
  wire logic engine_busy = (state != ST_IDLE);
  wire logic accept_poll = cmd_poll && !engine_busy;

  wire logic [31:0] status_word = {24'h000000, dpoll, toggle2, timeout_seen, etimer,
                                   i_ready_busy_n_pin, fail_flag, done_flag, engine_busy};
  wire logic [31:0] addr_word = {{(32-`FS_ADDR_W){1'b0}}, op_addr};
  wire logic [31:0] addr_merged = lane_merge(addr_word, i_wb_dat, i_wb_sel);
  wire logic [31:0] wdata_merged = lane_merge({16'h0000, wdata}, i_wb_dat, i_wb_sel);

  // unmapped addresses and the write-only control word read as zero
  wire logic [31:0] rd_mux =
    hit_addr ? addr_word :
    hit_wdata ? {16'h0000, wdata} :
    hit_status ? status_word :
    hit_rdata ? {16'h0000, rdata} :
    32'h00000000;

  // ----------------------------------------------------------------
  // poll sequencing
  // ----------------------------------------------------------------
  wire logic in_poll = (state == ST_RD1) || (state == ST_RD2) || (state == ST_RD3);
  wire logic is_read_state = in_poll || (state == ST_SWRD);
  wire logic cyc_go = engine_busy && !issued;
  wire logic toggling = (cyc_rdata[`FS_DQ_TOGGLE1] != prev_dq[`FS_DQ_TOGGLE1]);
  wire logic rd2_ok = (state == ST_RD2) && cyc_done && !toggling;
  wire logic rd2_tmo = (state == ST_RD2) && cyc_done && toggling && cyc_rdata[`FS_DQ_TIMEOUT];
  wire logic rd3_ok = (state == ST_RD3) && cyc_done && !toggling;
  wire logic rst_end = (state == ST_RST) && cyc_done;
  wire logic set_done = rd2_ok || rd3_ok;
  wire logic next_done = set_done || (done_flag && !(status_clr && i_wb_dat[`FS_ST_DONE]));
  wire logic next_fail = rst_end || (fail_flag && !(status_clr && i_wb_dat[`FS_ST_FAIL]));

  // reset command goes to a fixed address; status reads use the bank address
  assign req.write = (state == ST_RST) || (state == ST_SWWR);
  assign req.addr = (state == ST_RST) ? `FS_RST_ADDR : op_addr;
  assign req.wdata = (state == ST_RST) ? `FS_RESET_CMD : wdata;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `FS_REG_RST;
      op_addr <= '0;
      wdata <= '0;
    end
    else
    begin
      o_wb_ack <= bus_req && !o_wb_ack;
      o_wb_dat <= (bus_req && !o_wb_ack) ? rd_mux : 32'h00000000;
      if (wr_ack && hit_addr)
        op_addr <= addr_merged[`FS_ADDR_W-1:0];
      if (wr_ack && hit_wdata)
        wdata <= wdata_merged[`FS_DATA_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state <= ST_IDLE;
      issued <= 1'b0;
      poll_reads <= 2'b00;
    end
    else
    begin
      if (cyc_go)
        issued <= 1'b1;
      else if (cyc_done)
        issued <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // a fresh poll always starts at the double read
          if (accept_poll)
          begin
            state <= ST_RD1;
            poll_reads <= 2'b00;
          end
          else if (cmd_write)
            state <= ST_SWWR;
          else if (cmd_read)
            state <= ST_SWRD;
        end
        ST_RD1:
        begin
          if (cyc_done)
          begin
            state <= ST_RD2;
            poll_reads <= 2'b01;
          end
        end
        ST_RD2:
        begin
          if (cyc_done)
          begin
            poll_reads <= 2'b10;
            if (!toggling)
              state <= ST_IDLE;
            else if (cyc_rdata[`FS_DQ_TIMEOUT])
              state <= ST_RD3;
            else if (cmd_abort)
              state <= ST_IDLE;
            else
              state <= ST_RD1;
          end
        end
        ST_RD3:
        begin
          if (cyc_done)
          begin
            poll_reads <= 2'b11;
            state <= toggling ? ST_RST : ST_IDLE;
          end
        end
        ST_RST:
        begin
          if (cyc_done)
            state <= ST_IDLE;
        end
        ST_SWRD, ST_SWWR:
        begin
          if (cyc_done)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // captured status
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      rdata <= '0;
      prev_dq <= '0;
      etimer <= 1'b0;
      timeout_seen <= 1'b0;
      toggle2 <= 1'b0;
      dpoll <= 1'b0;
    end
    else
    begin
      done_flag <= next_done;
      fail_flag <= next_fail;
      if (cyc_done && is_read_state)
      begin
        rdata <= cyc_rdata;
        prev_dq <= cyc_rdata;
        // erase timer sampled on every read so software sees it around commands
        etimer <= cyc_rdata[`FS_DQ_ETIMER];
        timeout_seen <= cyc_rdata[`FS_DQ_TIMEOUT];
        dpoll <= cyc_rdata[`FS_DQ_POLL];
        if (state != ST_RD1)
          toggle2 <= cyc_rdata[`FS_DQ_TOGGLE2] != prev_dq[`FS_DQ_TOGGLE2];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin cycle engine
  // ----------------------------------------------------------------
  flash_cycle #(
    .RD_CYC(RD_CYC),
    .WR_CYC(WR_CYC),
    .REC_CYC(REC_CYC)
  ) u_cycle (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_go(cyc_go),
    .i_req(req),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_strobe(strobe),
    .o_addr(o_flash_addr),
    .o_dq_out(o_flash_dq_out),
    .o_dq_oe(o_flash_dq_oe),
    .i_dq_in(i_flash_dq_in)
  );

  assign o_flash_ce_n = strobe.ce_n;
  assign o_flash_oe_n = strobe.oe_n;
  assign o_flash_we_n = strobe.we_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_done_two_reads: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    set_done |-> (state == ST_RD2 || state == ST_RD3) && poll_reads >= 2'b01)
    else $error("done without a double read");

  chk_recheck_timeout: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd2_tmo |=> state == ST_RD3)
    else $error("timeout recheck not taken");

  chk_poll_restart: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_IDLE && cmd_poll) |=> state == ST_RD1 && poll_reads == 2'b00 && !issued)
    else $error("poll did not restart at first read");

  chk_reset_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RST && cyc_go) |-> req.write && req.wdata == `FS_RESET_CMD)
    else $error("reset command not sent");

  chk_fail_after_rst: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(fail_flag) |-> $past(state) == ST_RST && $past(cyc_done))
    else $error("failure flagged without reset command");

  chk_bank_addr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (cyc_go && in_poll) |=> o_flash_addr == $past(op_addr) && !o_flash_ce_n)
    else $error("status read left the bank address");

  chk_timer_capture: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (cyc_done && is_read_state) |=> etimer == $past(cyc_rdata[`FS_DQ_ETIMER]))
    else $error("erase timer bit not captured");

  chk_wb_ack_pulse: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// >>> dv/flash_dev_model.sv
// Purpose: behavioural flash device answering status reads
// Assumes: one busy bank, status shown at any address while busy, only inside the sector while erase is suspended
// Notes: op kinds 0 program, 1 erase, 2 erase suspended, 3 timeout
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_defines.svh"
module flash_dev_model (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [`FS_ADDR_W-1:0] i_addr,
  input wire logic [`FS_DATA_W-1:0] i_dq,
  output logic [`FS_DATA_W-1:0] o_dq,
  output logic o_ready_busy_n_pin
);
  logic [15:0] mem [16];
  logic [15:0] pdat = 16'h0000;
  logic [15:0] held = 16'h0000;
  logic [10:0] sec = 11'h000;
  logic [1:0] kind = 2'h0;
  logic busy = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  int left = 0;
  int reads = 0;
  wire in_sec = (i_addr[22:12] == sec);
  wire show = busy && (kind != 2'h2 || in_sec);
  wire dpoll = (kind == 2'h0 || kind == 2'h3) ? ~pdat[7] : (kind == 2'h2);
  wire [15:0] stat = {8'h00, dpoll, t1, kind == 2'h3, 1'b0, kind == 2'h1, t2, 2'b00};
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign o_ready_busy_n_pin = !(busy && kind != 2'h2);
  // ------------------------------------------------------------
  // read port: released lines show the inverse, never a held copy
  // ------------------------------------------------------------
  always @*
  begin
    if (!i_ce_n && !i_oe_n)
    begin
      o_dq = show ? stat : mem[i_addr[3:0]];
      held = o_dq;
    end
    else
      o_dq = ~held;
  end
  task automatic start_op(input logic [1:0] k, input int n, input logic [10:0] s,
                          input logic [15:0] d);
    kind = k;
    left = n;
    sec = s;
    pdat = d;
    reads = 0;
    busy = 1'b1;
  endtask
  always @(posedge i_oe_n)
  begin
    reads++;
    if (busy)
    begin
      if (kind != 2'h2)
        t1 = ~t1;
      if (kind != 2'h0 && in_sec)
        t2 = ~t2;
      if (kind < 2'h2)
        left--;
      if (kind < 2'h2 && left == 0)
        busy = 1'b0;
    end
  end
  always @(posedge i_we_n)
  begin
    if (i_dq == `FS_RESET_CMD)
      busy = 1'b0;
    else if (!(busy && kind == 2'h1))
      mem[i_addr[3:0]] = mem[i_addr[3:0]] & i_dq;
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the flash status poller
// Assumes: the poller acks each bus request one cycle after seeing it
// Notes: random values come from a fixed-seed xorshift
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_defines.svh"
module tb_top;
  logic clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, seed = 32'd42982;
  wire [31:0] wb_q;
  wire ack, ce_n, oe_n, we_n, dq_oe, rb_n;
  wire [`FS_ADDR_W-1:0] faddr;
  wire [`FS_DATA_W-1:0] dq_o, dev_dq;
  wire [`FS_DATA_W-1:0] dq = dq_oe ? dq_o : dev_dq;
  int error_cnt = 0, n_tests = 0;
  initial forever #5 clk = ~clk;
  flash_status_poller uut (.i_core_clk(clk), .i_nrst(i_nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_dat(wb_q), .o_wb_ack(ack), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n),
    .o_flash_we_n(we_n), .o_flash_addr(faddr), .o_flash_dq_out(dq_o),
    .o_flash_dq_oe(dq_oe), .i_flash_dq_in(dq), .i_ready_busy_n_pin(rb_n));
  flash_dev_model dev (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(faddr),
    .i_dq(dq), .o_dq(dev_dq), .o_ready_busy_n_pin(rb_n));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // toggle value of read i; array data after the op has bit6 clear
  function automatic logic tgl(input logic t0, input int n, input int i);
    return (i <= n) ? (t0 ^ ~i[0]) : 1'b0;
  endfunction
  function automatic int exp_reads(input logic t0, input int n);
    for (int k = 1; k < 40; k += 2)
      if (tgl(t0, n, k) == tgl(t0, n, k + 1))
        return k + 1;
    return 0;
  endfunction
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = wb_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      chk("bus answer", 32'h1, 32'h0);
  endtask
  // one engine command, then status reads until idle
  task automatic run(input int c);
    int n;
    wb(1'b1, `FS_REG_CTRL, 32'h1 << c);
    n = 0;
    do
    begin
      wb(1'b0, `FS_REG_STATUS, 32'h0);
      n++;
    end while (rdat[`FS_ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200)
      chk("engine idle", 32'h0, 32'h1);
  endtask
  task automatic two_reads(input logic [31:0] a, input logic [31:0] e);
    wb(1'b1, `FS_REG_ADDR, a);
    run(`FS_CTRL_READ);
    run(`FS_CTRL_READ);
    chk("status bits", e, rdat & 32'hf8);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int n;
    logic [31:0] d;
    logic t0;
    repeat (6) @(posedge clk);
    i_nrst <= 1'b1;
    wb(1'b0, `FS_REG_STATUS, 32'h0);
    chk("status at reset", 32'h8, rdat);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rdat);
    d = xs();
    wb(1'b1, `FS_REG_ADDR, d);
    wb(1'b0, `FS_REG_ADDR, 32'h0);
    chk("addr reg", d & 32'h7fffff, rdat);
    wb(1'b1, `FS_REG_ADDR, 32'h1);
    wb(1'b1, `FS_REG_WDATA, d);
    wb(1'b0, `FS_REG_WDATA, 32'h0);
    chk("wdata reg", d & 32'hffff, rdat);
    run(`FS_CTRL_WRITE);
    chk("array word", d & 32'hffff, {16'h0, dev.mem[1]});
    run(`FS_CTRL_READ);
    wb(1'b0, `FS_REG_RDATA, 32'h0);
    chk("read data", d & 32'hffff, rdat);
    wb(1'b1, `FS_REG_ADDR, 32'h2);
    wb(1'b1, `FS_REG_WDATA, 32'h11);
    run(`FS_CTRL_WRITE);
    for (int i = 0; i < 4; i++)
    begin
      n = 1 + int'(xs() % 6);
      d = xs();
      t0 = dev.t1;
      dev.start_op(2'h0, n, 11'h000, d[15:0]);
      wb(1'b0, `FS_REG_STATUS, 32'h0);
      chk("pin busy", 32'h0, rdat[`FS_ST_RBPIN]);
      run(`FS_CTRL_POLL);
      chk("poll reads", exp_reads(t0, n), dev.reads);
      chk("poll done", 32'ha, rdat & 32'hf);
      wb(1'b1, `FS_REG_STATUS, 32'h6);
    end
    dev.start_op(2'h0, 3, 11'h000, 16'h0011);
    two_reads(32'h2, 32'h80);
    run(`FS_CTRL_POLL);
    chk("program done", 32'h2, rdat & 32'h7);
    wb(1'b1, `FS_REG_STATUS, 32'h6);
    dev.start_op(2'h1, 8, 11'h000, 16'h0);
    two_reads(32'h2, 32'h50);
    two_reads(32'h1002, 32'h10);
    wb(1'b1, `FS_REG_ADDR, 32'h2);
    run(`FS_CTRL_POLL);
    chk("erase done", 32'ha, rdat & 32'hf);
    wb(1'b1, `FS_REG_STATUS, 32'h6);
    dev.start_op(2'h3, 0, 11'h000, 16'h0);
    run(`FS_CTRL_POLL);
    chk("timeout reads", 32'd3, dev.reads);
    chk("reset command", 32'h0, {31'h0, dev.busy});
    chk("fail flag", 32'h2c, rdat & 32'h2f);
    wb(1'b1, `FS_REG_STATUS, 32'h6);
    wb(1'b0, `FS_REG_STATUS, 32'h0);
    chk("flags cleared", 32'h0, rdat & 32'h6);
    // abort only acts at the end of a second read, so keep asking
    dev.start_op(2'h0, 40, 11'h000, 16'h0);
    wb(1'b1, `FS_REG_CTRL, 32'h1 << `FS_CTRL_POLL);
    repeat (30) wb(1'b1, `FS_REG_CTRL, 32'h1 << `FS_CTRL_ABORT);
    wb(1'b0, `FS_REG_STATUS, 32'h0);
    chk("abort status", 32'h0, rdat & 32'h3);
    chk("abort pairs", 32'h0, dev.reads % 2);
    chk("op still busy", 32'h1, {31'h0, dev.busy});
    dev.start_op(2'h2, 0, 11'h000, 16'h0);
    run(`FS_CTRL_POLL);
    chk("suspend reads", 32'd2, dev.reads);
    chk("suspend status", 32'hca, rdat & 32'hff);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
